// ### rtl/mcu_pkg.sv
// Purpose: shared constants and types for the small 8-bit controller core
// Assumes: 18-bit instructions, 10-bit program address, one clock
// Notes: the instruction encoding is a house encoding; see opcode enum
package mcu_pkg;
    localparam int unsigned prog_aw = 10;
    localparam int unsigned instr_w = 18;
    localparam int unsigned data_w = 8;
    localparam int unsigned gp_count = 16;
    localparam int unsigned ram_depth = 64;
    localparam int unsigned ram_aw = 6;
    localparam int unsigned stack_depth = 31;
    localparam int unsigned stack_aw = 5;
    localparam logic [9:0] reset_pc = 10'h000;
    localparam logic [9:0] irq_vector = 10'h3FF;
    localparam logic [4:0] stack_empty = 5'h00;
    // instruction fields
    localparam int unsigned op_msb = 17;
    localparam int unsigned op_lsb = 13;
    localparam int unsigned imm_sel_bit = 12;
    localparam int unsigned rx_msb = 11;
    localparam int unsigned rx_lsb = 8;
    localparam int unsigned ry_msb = 7;
    localparam int unsigned ry_lsb = 4;
    localparam int unsigned cond_msb = 11;
    localparam int unsigned cond_lsb = 10;
    localparam int unsigned cond_en_bit = 12;
    localparam int unsigned ie_bit = 0;

    // opcodes, 5-bit field
    typedef enum logic [4:0] {
        op_load = 5'h00, op_and = 5'h01, op_or = 5'h02, op_xor = 5'h03,
        op_add = 5'h04, op_addcy = 5'h05, op_sub = 5'h06, op_subcy = 5'h07,
        op_compare = 5'h08, op_test = 5'h09, op_shift = 5'h0A,
        op_fetch = 5'h0B, op_store = 5'h0C, op_input = 5'h0D,
        op_output = 5'h0E, op_jump = 5'h0F, op_call = 5'h10,
        op_return = 5'h11, op_reti = 5'h12, op_intctl = 5'h13
    } opcode_t;

    // condition codes for jump, call and return
    typedef enum logic [1:0] {
        cond_z = 2'h0, cond_nz = 2'h1, cond_c = 2'h2, cond_nc = 2'h3
    } cond_t;

    typedef struct packed {
        logic zero;
        logic carry;
    } flags_t;

    typedef struct packed {
        logic [7:0] select;
        logic [7:0] data;
        logic read_pulse;
        logic write_pulse;
    } port_bus_t;
endpackage

// ### rtl/mcu_ram.sv
// Purpose: small synchronous memory for scratch data and return stack
// Assumes: one write port, one read port, registered read data
// Notes: no reset of contents; software must write before reading
`timescale 1ns/100ps
module mcu_ram #(
    parameter int unsigned width = 8,
    parameter int unsigned depth = 64,
    parameter int unsigned aw = 6
) (
    input wire logic clock,
    input wire logic clock_en,
    input wire logic wr_en,
    input wire logic [aw-1:0] wr_addr,
    input wire logic [width-1:0] wr_data,
    input wire logic [aw-1:0] rd_addr,
    output logic [width-1:0] rd_data
);
    logic [width-1:0] mem [depth];

    // write and registered read
    always_ff @(posedge clock) begin
        if (clock_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end
endmodule // mcu_ram

// ### rtl/mcu_core.sv
// Purpose: 8-bit controller core, two clocks per instruction
// Assumes: program store shows the word for prog_addr within one clock
// Notes: port strobes and interrupt acknowledge are one-cycle pulses
`timescale 1ns/100ps
// Overview of operation
// - 10-bit fetch address, 18-bit instruction input
// - every instruction takes exactly two clocks
// - sixteen 8-bit general registers
// - internal 64-byte scratch memory
// - 31-entry call/return address stack
// - alu ops other than compare and test write result to first register
// - second operand is register or constant
// - zero flag follows result equal zero
// - carry flag set on arithmetic overflow
// - jump and call conditional on flags
// - 8-bit port select for 256 ports
// - port select from constant or register
// - input byte loaded into chosen register
// - output places register byte on bus
// - accepted interrupt forces pc to 0x3FF
// - ack pulse, flags saved, interrupts disabled
// - interrupt return restores flags, loads enable from instruction bit 0
module mcu_core (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clock_en,
    input wire logic [17:0] instr,
    input wire logic [7:0] in_data,
    input wire logic irq,
    output logic [9:0] prog_addr,
    output mcu_pkg::port_bus_t port_bus,
    output logic irq_ack
);
    typedef enum logic {st_fetch, st_exec} phase_t;

    phase_t phase, next_phase;
    logic [9:0] pc, next_pc;
    logic [9:0] next_prog_addr;
    mcu_pkg::flags_t flags, next_flags, saved_flags, next_saved_flags;
    logic irq_enable, next_irq_enable;
    logic [4:0] sp, next_sp;
    mcu_pkg::port_bus_t next_port_bus;
    logic next_irq_ack;
    logic [7:0] gp_reg [16];
    logic gp_we;
    logic [3:0] gp_waddr;
    logic [7:0] gp_wdata;
    logic ram_we;
    logic stack_we;
    logic [9:0] stack_rd;
    logic [7:0] ram_rd;

    // decoded fields
    logic [4:0] opcode;
    logic use_imm;
    logic [3:0] rx, ry;
    logic [7:0] opx, opy, imm;
    assign opcode = instr[mcu_pkg::op_msb:mcu_pkg::op_lsb];
    assign use_imm = instr[mcu_pkg::imm_sel_bit];
    assign rx = instr[mcu_pkg::rx_msb:mcu_pkg::rx_lsb];
    assign ry = instr[mcu_pkg::ry_msb:mcu_pkg::ry_lsb];
    assign imm = instr[7:0];
    assign opx = gp_reg[rx];
    assign opy = use_imm ? imm : gp_reg[ry];

    // condition test shared by jump, call and return
    function automatic logic cond_met(input logic [17:0] iw,
                                      input mcu_pkg::flags_t f);
        logic [1:0] c;
        c = iw[mcu_pkg::cond_msb:mcu_pkg::cond_lsb];
        if (!iw[mcu_pkg::cond_en_bit]) begin
            return 1'b1;
        end else if (c == mcu_pkg::cond_z) begin
            return f.zero;
        end else if (c == mcu_pkg::cond_nz) begin
            return !f.zero;
        end else if (c == mcu_pkg::cond_c) begin
            return f.carry;
        end else begin
            return !f.carry;
        end
    endfunction

    // scratch memory, read address taken in fetch phase
    mcu_ram #(.width(8), .depth(mcu_pkg::ram_depth), .aw(6)) scratch (
        .clock(clock),
        .clock_en(clock_en),
        .wr_en(ram_we),
        .wr_addr(opy[5:0]),
        .wr_data(opx),
        .rd_addr(opy[5:0]),
        .rd_data(ram_rd)
    );

    // return stack; top entry sits at sp-1
    mcu_ram #(.width(10), .depth(32), .aw(5)) stack (
        .clock(clock),
        .clock_en(clock_en),
        .wr_en(stack_we),
        .wr_addr(sp),
        .wr_data(pc),
        .rd_addr(sp - 5'h01),
        .rd_data(stack_rd)
    );

    // alu and control: next-state for the sequencer
    logic [8:0] alu;
    logic alu_write, alu_flags, is_take;
    always_comb begin
        next_phase = phase;
        next_pc = pc;
        next_prog_addr = prog_addr;
        next_flags = flags;
        next_saved_flags = saved_flags;
        next_irq_enable = irq_enable;
        next_sp = sp;
        next_port_bus = port_bus;
        next_port_bus.read_pulse = 1'b0;
        next_port_bus.write_pulse = 1'b0;
        next_irq_ack = 1'b0;
        gp_we = 1'b0;
        gp_waddr = rx;
        gp_wdata = 8'h00;
        ram_we = 1'b0;
        stack_we = 1'b0;
        alu = 9'h000;
        alu_write = 1'b1;
        alu_flags = 1'b1;
        is_take = cond_met(instr, flags);
        if (phase == st_fetch) begin
            // instruction word now valid; present port address early
            next_phase = st_exec;
            if (opcode == mcu_pkg::op_input) begin
                next_port_bus.select = opy;
                next_port_bus.read_pulse = 1'b1;
            end else if (opcode == mcu_pkg::op_output) begin
                next_port_bus.select = opy;
                next_port_bus.data = opx;
                next_port_bus.write_pulse = 1'b1;
            end
        end else begin
            next_phase = st_fetch;
            next_pc = pc + 10'h001;
            case (opcode)
                mcu_pkg::op_load: alu = {1'b0, opy};
                mcu_pkg::op_and: alu = {1'b0, opx & opy};
                mcu_pkg::op_or: alu = {1'b0, opx | opy};
                mcu_pkg::op_xor: alu = {1'b0, opx ^ opy};
                mcu_pkg::op_add: alu = {1'b0, opx} + {1'b0, opy};
                mcu_pkg::op_addcy:
                    alu = {1'b0, opx} + {1'b0, opy} + {8'h00, flags.carry};
                mcu_pkg::op_sub: alu = {1'b0, opx} - {1'b0, opy};
                mcu_pkg::op_subcy:
                    alu = {1'b0, opx} - {1'b0, opy} - {8'h00, flags.carry};
                mcu_pkg::op_compare: begin
                    alu = {1'b0, opx} - {1'b0, opy};
                    alu_write = 1'b0;
                end
                mcu_pkg::op_test: begin
                    alu = {^(opx & opy), opx & opy};
                    alu_write = 1'b0;
                end
                mcu_pkg::op_shift: begin
                    // imm bits: 7 = right, 2:0 = fill (0,1,x,c,rotate)
                    if (imm[7]) begin
                        alu[7:0] = {(imm[2:0] == 3'h4) ? opx[0] :
                                    (imm[2:0] == 3'h3) ? flags.carry :
                                    (imm[2:0] == 3'h2) ? opx[7] : imm[0],
                                    opx[7:1]};
                        alu[8] = opx[0];
                    end else begin
                        alu[7:0] = {opx[6:0],
                                    (imm[2:0] == 3'h4) ? opx[7] :
                                    (imm[2:0] == 3'h3) ? flags.carry :
                                    (imm[2:0] == 3'h2) ? opx[0] : imm[0]};
                        alu[8] = opx[7];
                    end
                end
                mcu_pkg::op_fetch: begin
                    alu = {1'b0, ram_rd};
                    alu_flags = 1'b0;
                end
                mcu_pkg::op_store: begin
                    ram_we = 1'b1;
                    alu_write = 1'b0;
                    alu_flags = 1'b0;
                end
                mcu_pkg::op_input: begin
                    alu = {1'b0, in_data};
                    alu_flags = 1'b0;
                end
                default: begin
                    alu_write = 1'b0;
                    alu_flags = 1'b0;
                    if (opcode == mcu_pkg::op_jump && is_take) begin
                        next_pc = instr[9:0];
                    end else if (opcode == mcu_pkg::op_call && is_take &&
                                 sp != 5'(mcu_pkg::stack_depth)) begin
                        stack_we = 1'b1;
                        next_sp = sp + 5'h01;
                        next_pc = instr[9:0];
                    end else if (opcode == mcu_pkg::op_return && is_take &&
                                 sp != mcu_pkg::stack_empty) begin
                        next_sp = sp - 5'h01;
                        next_pc = stack_rd + 10'h001;
                    end else if (opcode == mcu_pkg::op_reti &&
                                 sp != mcu_pkg::stack_empty) begin
                        next_sp = sp - 5'h01;
                        next_pc = stack_rd; // resume interrupted word
                        next_flags = saved_flags;
                        next_irq_enable = instr[mcu_pkg::ie_bit];
                    end else if (opcode == mcu_pkg::op_intctl) begin
                        next_irq_enable = instr[mcu_pkg::ie_bit];
                    end
                end
            endcase
            if (alu_write) begin
                gp_we = 1'b1;
                gp_wdata = alu[7:0];
            end
            if (alu_flags) begin
                next_flags.zero = (alu[7:0] == 8'h00);
                next_flags.carry = alu[8];
            end
            // interrupt taken at instruction boundary
            if (irq_enable && irq && sp != 5'(mcu_pkg::stack_depth)) begin
                stack_we = 1'b1; // return to the current word
                next_sp = sp + 5'h01;
                next_pc = mcu_pkg::irq_vector;
                next_saved_flags = flags;
                next_irq_enable = 1'b0;
                next_irq_ack = 1'b1;
            end
            next_prog_addr = next_pc;
        end
    end

    // interrupt return address: the word executing when the interrupt was taken
    // (stack_we writes pc of the current word when interrupting; reti resumes there)
    // sequencer registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase <= st_fetch;
            pc <= mcu_pkg::reset_pc;
            prog_addr <= mcu_pkg::reset_pc;
            flags <= '0;
            saved_flags <= '0;
            irq_enable <= 1'b0;
            sp <= mcu_pkg::stack_empty;
            port_bus <= '0;
            irq_ack <= 1'b0;
        end else if (clock_en) begin
            phase <= next_phase;
            pc <= next_pc;
            prog_addr <= next_prog_addr;
            flags <= next_flags;
            saved_flags <= next_saved_flags;
            irq_enable <= next_irq_enable;
            sp <= next_sp;
            port_bus <= next_port_bus;
            irq_ack <= next_irq_ack;
        end
    end

    // general register file, no reset
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_gp
            always_ff @(posedge clock) begin
                if (clock_en && gp_we && gp_waddr == 4'(gi)) begin
                    gp_reg[gi] <= gp_wdata;
                end
            end
        end
    endgenerate
endmodule // mcu_core

// ### test/mcu_core_checker.sv
// Purpose: port-level assertions for the controller core
// Assumes: one clock domain, reset active low
// Notes: attached to every core instance by bind
`timescale 1ns/100ps
module mcu_core_checker (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clock_en,
    input wire logic [17:0] instr,
    input wire logic [7:0] in_data,
    input wire logic irq,
    input wire logic [9:0] prog_addr,
    input wire mcu_pkg::port_bus_t port_bus,
    input wire logic irq_ack
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // either port strobe
    sequence io_strobe;
        port_bus.read_pulse || port_bus.write_pulse;
    endsequence
    // interrupt taken: ack seen with the request high before it
    sequence ack_taken;
        $past(irq) && irq_ack;
    endsequence
    a_addr_two_clk: assert property ($changed(prog_addr) |=> $stable(prog_addr))
        else $error("fetch address changed two clocks running");
    a_strobe_single: assert property (io_strobe |=> !io_strobe)
        else $error("port strobe longer than one cycle");
    a_read_no_write: assert property (port_bus.read_pulse |-> !port_bus.write_pulse)
        else $error("read and write strobes together");
    a_select_held: assert property ($changed(port_bus.select) |-> io_strobe)
        else $error("port select moved without a strobe");
    a_data_held: assert property ($changed(port_bus.data) |-> port_bus.write_pulse)
        else $error("output byte moved without write strobe");
    a_ack_single: assert property (irq_ack |=> !irq_ack)
        else $error("acknowledge longer than one cycle");
    a_ack_cause: assert property (irq_ack |-> ack_taken)
        else $error("acknowledge without a request");
    a_ack_vector: assert property (irq_ack |-> prog_addr == mcu_pkg::irq_vector)
        else $error("acknowledge without jump to vector");
    a_reset_start: assert property ($rose(arst_n) |-> prog_addr == mcu_pkg::reset_pc && !irq_ack)
        else $error("core not at start after reset");
endmodule // mcu_core_checker
bind mcu_core mcu_core_checker i_chk (.clock(clock), .arst_n(arst_n),
    .clock_en(clock_en), .instr(instr), .in_data(in_data), .irq(irq),
    .prog_addr(prog_addr), .port_bus(port_bus), .irq_ack(irq_ack));

// ### test/mcu_prog_model.sv
// Purpose: program store and port logic around the core
// Assumes: program word follows prog_addr within the same clock
// Notes: rom is filled by the bench; writes are logged
`timescale 1ns/100ps
module mcu_prog_model (
    input wire logic clock,
    input wire logic [9:0] prog_addr,
    output logic [17:0] instr,
    input wire mcu_pkg::port_bus_t port_bus,
    output logic [7:0] in_data
);
    logic [17:0] rom [0:1023];
    logic [15:0] wr_log [0:7];
    int wr_count = 0;
    // word for the current address; the core decodes it at both edges
    assign instr = rom[prog_addr];
    // byte only valid during a read; scrambled otherwise
    always_comb begin
        in_data = port_bus.select ^ 8'h5A;
        if (!port_bus.read_pulse) begin
            in_data = ~in_data;
        end
    end
    // capture every output write
    always @(posedge clock) begin
        if (port_bus.write_pulse) begin
            wr_log[wr_count[2:0]] <= {port_bus.select, port_bus.data};
            wr_count <= wr_count + 1;
        end
    end
endmodule // mcu_prog_model

// ### test/tiny_8bit_microcontroller_tb.sv
// Purpose: self-checking bench for the controller core
// Assumes: program loaded into the model before reset release
// Notes: a short program exercises flags, ports and interrupt
`timescale 1ns/100ps
module tiny_8bit_microcontroller_tb;
    logic clock;
    logic arst_n;
    logic clock_en;
    logic irq;
    logic [17:0] instr;
    logic [7:0] in_data;
    logic [9:0] prog_addr;
    mcu_pkg::port_bus_t port_bus;
    logic irq_ack;
    int bad_count = 0;
    int checks_done = 0;
    mcu_core i_dut (.clock(clock), .arst_n(arst_n), .clock_en(clock_en),
        .instr(instr), .in_data(in_data), .irq(irq),
        .prog_addr(prog_addr), .port_bus(port_bus), .irq_ack(irq_ack));
    mcu_prog_model i_mem (.clock(clock), .prog_addr(prog_addr),
        .instr(instr), .port_bus(port_bus), .in_data(in_data));
    // free-running clock
    always #4 clock = ~clock;
    function automatic logic [17:0] alu(mcu_pkg::opcode_t op, logic imm,
        logic [3:0] rx, logic [7:0] lo);
        return {op, imm, rx, lo};
    endfunction
    function automatic logic [17:0] jmp(logic cen, mcu_pkg::cond_t cc,
        logic [9:0] dest);
        return {mcu_pkg::op_jump, cen, cc, dest};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic test_reset();
        #1;
        check({5'h00, irq_ack, prog_addr}, 16'h0000);
        check({14'h0000, port_bus[1:0]}, 16'h0000);
    endtask
    // carry jump, zero jump, input and register-selected output
    task automatic test_program();
        int n;
        for (n = 0; n < 200 && i_mem.wr_count < 2; n++) @(posedge clock);
        check(16'(i_mem.wr_count), 16'h0002);
        check(i_mem.wr_log[0], {8'h11, 8'h3C + 8'hD0});
        check(i_mem.wr_log[1], {2{8'h33 ^ 8'h5A}});
    endtask
    task automatic test_irq();
        int n;
        repeat (6) @(posedge clock);
        irq <= 1'b1;
        for (n = 1; n < 5; n++) begin
            @(posedge clock);
            #1;
            if (irq_ack === 1'b1) break;
        end
        check(16'(n >= 1 && n <= 2), 16'h0001);
        check({6'h00, prog_addr}, 16'h03FF);
        @(posedge clock);
        irq <= 1'b0;
        repeat (10) @(posedge clock);
        check(i_mem.wr_log[2], {8'h77, 8'h33 ^ 8'h5A});
    endtask
    // a second request while disabled is ignored
    task automatic test_irq_masked();
        logic seen;
        seen = 1'b0;
        irq <= 1'b1;
        repeat (8) begin
            @(posedge clock);
            #1;
            if (irq_ack !== 1'b0) seen = 1'b1;
        end
        check({6'h00, prog_addr}, 16'h000B);
        @(posedge clock);
        irq <= 1'b0;
        clock_en <= 1'b0;
        repeat (4) @(posedge clock);
        #1;
        check({6'h00, prog_addr}, 16'h000B);
        @(posedge clock);
        clock_en <= 1'b1;
        check({15'h0000, seen}, 16'h0000);
        check(16'(i_mem.wr_count), 16'h0003);
    endtask
    // main sequence
    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        clock_en = 1'b1;
        irq = 1'b0;
        i_mem.rom[0] = alu(mcu_pkg::op_load, 1'b1, 4'h1, 8'h3C);
        i_mem.rom[1] = alu(mcu_pkg::op_add, 1'b1, 4'h1, 8'hD0);
        i_mem.rom[2] = jmp(1'b1, mcu_pkg::cond_c, 10'h004);
        i_mem.rom[3] = alu(mcu_pkg::op_output, 1'b1, 4'h1, 8'hEE);
        i_mem.rom[4] = alu(mcu_pkg::op_output, 1'b1, 4'h1, 8'h11);
        i_mem.rom[5] = alu(mcu_pkg::op_sub, 1'b0, 4'h1, 8'h10);
        i_mem.rom[6] = jmp(1'b1, mcu_pkg::cond_z, 10'h008);
        i_mem.rom[7] = alu(mcu_pkg::op_output, 1'b1, 4'h1, 8'hEE);
        i_mem.rom[8] = alu(mcu_pkg::op_input, 1'b1, 4'h2, 8'h33);
        i_mem.rom[9] = alu(mcu_pkg::op_output, 1'b0, 4'h2, 8'h20);
        i_mem.rom[10] = alu(mcu_pkg::op_intctl, 1'b0, 4'h0, 8'h01);
        i_mem.rom[11] = jmp(1'b0, mcu_pkg::cond_z, 10'h00B);
        i_mem.rom[12] = alu(mcu_pkg::op_output, 1'b1, 4'h2, 8'h77);
        i_mem.rom[13] = alu(mcu_pkg::op_reti, 1'b0, 4'h0, 8'h00);
        i_mem.rom[1023] = jmp(1'b0, mcu_pkg::cond_z, 10'h00C);
        @(posedge clock);
        test_reset();
        @(posedge clock);
        arst_n <= 1'b1;
        test_program();
        test_irq();
        test_irq_masked();
        stop_test();
    end
    // watchdog against a hung core
    initial begin
        repeat (2000) @(posedge clock);
        bad_count++;
        stop_test();
    end
endmodule // tiny_8bit_microcontroller_tb
